// [twi_pkg.sv]
package twi_pkg;
    // Field widths
    localparam int ADDR_W = 10;
    localparam int DIV_W = 12;
    localparam int BYTE_W = 8;
    localparam int EV_W = 5;
    // Register byte offsets
    localparam logic [7:0] OFS_OWN = 8'h00;
    localparam logic [7:0] OFS_MASK = 8'h04;
    localparam logic [7:0] OFS_DIV = 8'h08;
    localparam logic [7:0] OFS_TX = 8'h0C;
    localparam logic [7:0] OFS_RX = 8'h10;
    localparam logic [7:0] OFS_CTRL = 8'h14;
    localparam logic [7:0] OFS_STAT = 8'h18;
    localparam logic [7:0] OFS_IRQ = 8'h1C;
    localparam logic [7:0] OFS_IMSK = 8'h20;
    // Values after reset
    localparam logic [9:0] ADDR_RST = 10'h000;
    localparam logic [11:0] DIV_RST = 12'h000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    // Event positions in the interrupt status and mask
    localparam int EV_RX = 0;
    localparam int EV_OV = 1;
    localparam int EV_WCOL = 2;
    localparam int EV_TXDONE = 3;
    localparam int EV_MATCH = 4;
    // Bit counts: eight data bits, then the acknowledge slot
    localparam logic [3:0] LAST_DATA = 4'h7;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    // Leading five bits of a 10-bit address header
    localparam logic [4:0] TEN_HDR = 5'h1E;
    // Software controls
    typedef struct packed {
        logic ten_bit_mode_flag;
        logic enable;
    } ctrl_t;
    // Status seen by software
    typedef struct packed {
        logic matched;
        logic busy;
        logic write_collision_flag;
        logic receive_overflow_flag;
        logic receive_full_status;
    } stat_t;
    // Address phase tracking of the bus listener
    typedef enum logic [1:0] {
        LS_IDLE = 2'b00,
        LS_FIRST = 2'b01,
        LS_SECOND = 2'b10,
        LS_DATA = 2'b11
    } listen_t;
endpackage

// [twi_addr_data_regs.sv]
// Design decisions made here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module twi_addr_data_regs (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Two-wire bus pins, open drain
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // Interrupt
    output logic irq
);
    logic [9:0] own_q;
    logic [9:0] mask_q;
    logic [11:0] div_q;
    logic [7:0] tx_q;
    logic [7:0] rx_q;
    twi_pkg::ctrl_t ctrl_q;
    twi_pkg::stat_t stat_q;
    twi_pkg::stat_t stat_d;
    logic [4:0] irq_q;
    logic [4:0] imsk_q;
    logic [4:0] ev;

    // Bus phase registers
    logic wr_ph_q;
    logic rd_ph_q;
    logic rd_done_q;
    logic [7:0] ofs_q;
    logic [31:0] hrdata_q;
    wire addr_ok = hsel & htrans[1] & hready;
    wire rd_load = rd_ph_q & ~rd_done_q;

    // Reads take one wait state so a write just before is seen
    assign hreadyout = ~rd_load;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wr_ph_q <= 1'b0;
            rd_ph_q <= 1'b0;
            rd_done_q <= 1'b0;
            ofs_q <= 8'h00;
        end else begin
            wr_ph_q <= addr_ok & hwrite;
            rd_done_q <= rd_load;
            if (addr_ok) begin
                ofs_q <= haddr[7:0];
            end
            if (addr_ok & ~hwrite) begin
                rd_ph_q <= 1'b1;
            end else if (rd_done_q) begin
                rd_ph_q <= 1'b0;
            end
        end
    end

    // Decoded strobes in the data phase
    wire wr_own = wr_ph_q & (ofs_q == twi_pkg::OFS_OWN);
    wire wr_mask = wr_ph_q & (ofs_q == twi_pkg::OFS_MASK);
    wire wr_div = wr_ph_q & (ofs_q == twi_pkg::OFS_DIV);
    wire wr_tx = wr_ph_q & (ofs_q == twi_pkg::OFS_TX);
    wire wr_rx = wr_ph_q & (ofs_q == twi_pkg::OFS_RX);
    wire wr_ctrl = wr_ph_q & (ofs_q == twi_pkg::OFS_CTRL);
    wire wr_stat = wr_ph_q & (ofs_q == twi_pkg::OFS_STAT);
    wire wr_imsk = wr_ph_q & (ofs_q == twi_pkg::OFS_IMSK);
    wire rd_rx = rd_load & (ofs_q == twi_pkg::OFS_RX);
    wire rd_irq = rd_load & (ofs_q == twi_pkg::OFS_IRQ);

    // Read mux; unused upper bits and unmapped offsets read zero
    logic [31:0] rmux;
    always_comb begin
        unique case (ofs_q)
            twi_pkg::OFS_OWN: rmux = {22'h0, own_q};
            twi_pkg::OFS_MASK: rmux = {22'h0, mask_q};
            twi_pkg::OFS_DIV: rmux = {20'h00000, div_q};
            twi_pkg::OFS_TX: rmux = {24'h000000, tx_q};
            twi_pkg::OFS_RX: rmux = {24'h000000, rx_q};
            twi_pkg::OFS_CTRL: rmux = {30'h0, ctrl_q};
            twi_pkg::OFS_STAT: rmux = {27'h0, stat_q};
            twi_pkg::OFS_IRQ: rmux = {27'h0, irq_q};
            twi_pkg::OFS_IMSK: rmux = {27'h0, imsk_q};
            default: rmux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            hrdata_q <= 32'h00000000;
        end else if (rd_load) begin
            hrdata_q <= rmux;
        end
    end

    // Pin synchronisers
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_d1;
    logic sda_d1;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            scl_s <= 2'b11;
            sda_s <= 2'b11;
            scl_d1 <= 1'b1;
            sda_d1 <= 1'b1;
        end else begin
            scl_s <= {scl_s[0], scl_i};
            sda_s <= {sda_s[0], sda_i};
            scl_d1 <= scl_s[1];
            sda_d1 <= sda_s[1];
        end
    end
    wire scl = scl_s[1];
    wire sda = sda_s[1];
    wire scl_rise = scl & ~scl_d1;
    wire start_c = scl & scl_d1 & sda_d1 & ~sda;
    wire stop_c = scl & scl_d1 & ~sda_d1 & sda;

    // Bus listener: bit counter and byte shifter
    twi_pkg::listen_t ls_q;
    twi_pkg::listen_t ls_d;
    logic [3:0] lbit_q;
    logic [7:0] lsh_q;
    wire [7:0] lsh_n = {lsh_q[6:0], sda};
    wire byte_done = scl_rise & (lbit_q == twi_pkg::LAST_DATA);
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            lbit_q <= 4'h0;
            lsh_q <= 8'h00;
        end else if (start_c) begin
            lbit_q <= 4'h0;
        end else if (scl_rise) begin
            lsh_q <= lsh_n;
            lbit_q <= (lbit_q == twi_pkg::ACK_SLOT) ? 4'h0 : lbit_q + 4'h1;
        end
    end

    // Masked compares: a set mask bit removes the position
    // mask ignores bit
    wire [9:0] diff = ~mask_q & (own_q ^ {own_q[9:8], lsh_n});
    wire hit7 = (diff[7:1] == 7'h00);
    wire [1:0] hdiff = ~mask_q[9:8] & (own_q[9:8] ^ lsh_n[2:1]);
    wire hit_hdr = (lsh_n[7:3] == twi_pkg::TEN_HDR) & (hdiff == 2'b00);
    wire hit_lo = (diff[7:0] == 8'h00);

    // Address tracking; 10-bit needs header then low byte
    // address width select
    always_comb begin
        ls_d = ls_q;
        if (!ctrl_q.enable || stop_c) begin
            ls_d = twi_pkg::LS_IDLE;
        end else if (start_c) begin
            ls_d = twi_pkg::LS_FIRST;
        end else if (byte_done) begin
            unique case (ls_q)
                twi_pkg::LS_IDLE: ls_d = twi_pkg::LS_IDLE;
                twi_pkg::LS_FIRST: begin
                    if (ctrl_q.ten_bit_mode_flag) begin
                        ls_d = hit_hdr ? twi_pkg::LS_SECOND
                                       : twi_pkg::LS_IDLE;
                    end else begin
                        ls_d = hit7 ? twi_pkg::LS_DATA
                                    : twi_pkg::LS_IDLE;
                    end
                end
                twi_pkg::LS_SECOND: begin
                    ls_d = hit_lo ? twi_pkg::LS_DATA : twi_pkg::LS_IDLE;
                end
                twi_pkg::LS_DATA: ls_d = twi_pkg::LS_DATA;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ls_q <= twi_pkg::LS_IDLE;
        end else begin
            ls_q <= ls_d;
        end
    end

    wire match_ev = (ls_d == twi_pkg::LS_DATA) & (ls_q != twi_pkg::LS_DATA);
    wire rx_ev = byte_done & (ls_q == twi_pkg::LS_DATA) & ctrl_q.enable;
    // A byte landing on a full register is dropped
    wire ov_ev = rx_ev & stat_q.receive_full_status;

    // Receive register
    // last received byte
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rx_q <= twi_pkg::BYTE_RST;
        end else if (rx_ev & ~stat_q.receive_full_status) begin
            rx_q <= lsh_n;
        end else if (wr_rx) begin
            rx_q <= hwdata[7:0];
        end
    end

    // Transmitter: bit index, shifter, clock phase
    logic busy_q;
    logic [3:0] tbit_q;
    logic [7:0] tsh_q;
    logic scl_hi_q;
    logic [11:0] cnt_q;
    logic tick;
    wire wcol_ev = wr_tx & busy_q;
    wire tx_go = wr_tx & ~busy_q & ctrl_q.enable;
    wire tx_done = tick & scl_hi_q & (tbit_q == twi_pkg::ACK_SLOT);

    // Divisor counter sets the half period of the bus clock
    // divide by divisor plus one
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= twi_pkg::DIV_RST;
        end else if (!ctrl_q.enable || !busy_q || cnt_q == 12'h000) begin
            cnt_q <= div_q;
        end else begin
            cnt_q <= cnt_q - 12'h001;
        end
    end
    assign tick = ctrl_q.enable & busy_q & (cnt_q == 12'h000);

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            busy_q <= 1'b0;
            tbit_q <= 4'h0;
            tsh_q <= twi_pkg::BYTE_RST;
            scl_hi_q <= 1'b1;
        end else if (!ctrl_q.enable) begin
            busy_q <= 1'b0;
            scl_hi_q <= 1'b1;
        end else if (tx_go) begin
            busy_q <= 1'b1;
            tbit_q <= 4'h0;
            tsh_q <= hwdata[7:0];
            scl_hi_q <= 1'b0;
        end else if (tick) begin
            scl_hi_q <= ~scl_hi_q;
            if (scl_hi_q) begin
                tsh_q <= {tsh_q[6:0], 1'b0};
                tbit_q <= tbit_q + 4'h1;
                busy_q <= ~tx_done;
            end
        end
    end

    // Open drain: only ever pull low; data line released in acknowledge slot
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe = busy_q & ~scl_hi_q;
    assign sda_oe = busy_q & (tbit_q != twi_pkg::ACK_SLOT) & ~tsh_q[7];

    // Configuration registers
    // own address
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            own_q <= twi_pkg::ADDR_RST;
            mask_q <= twi_pkg::ADDR_RST;
            div_q <= twi_pkg::DIV_RST;
            tx_q <= twi_pkg::BYTE_RST;
            ctrl_q <= '0;
            imsk_q <= 5'h00;
        end else begin
            if (wr_own) own_q <= hwdata[9:0];
            if (wr_mask) mask_q <= hwdata[9:0];
            if (wr_div) div_q <= hwdata[11:0];
            // Writable while idle, even disabled; busy writes only collide
            if (wr_tx & ~busy_q) tx_q <= hwdata[7:0];
            if (wr_ctrl) ctrl_q <= hwdata[1:0];
            if (wr_imsk) imsk_q <= hwdata[4:0];
        end
    end

    // Status: events win over software clears in the same cycle
    // full on receive
    always_comb begin
        stat_d = stat_q;
        if (rd_rx) stat_d.receive_full_status = 1'b0;
        if (rx_ev) stat_d.receive_full_status = 1'b1;
        if (wr_stat & hwdata[twi_pkg::EV_OV]) begin
            stat_d.receive_overflow_flag = 1'b0;
        end
        if (ov_ev) stat_d.receive_overflow_flag = 1'b1;
        if (wr_stat & hwdata[twi_pkg::EV_WCOL]) begin
            stat_d.write_collision_flag = 1'b0;
        end
        if (wcol_ev) stat_d.write_collision_flag = 1'b1;
        stat_d.busy = busy_q;
        stat_d.matched = (ls_d == twi_pkg::LS_DATA);
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            stat_q <= '0;
        end else begin
            stat_q <= stat_d;
        end
    end

    // Sticky events, cleared by reading them
    assign ev[twi_pkg::EV_RX] = rx_ev;
    assign ev[twi_pkg::EV_OV] = ov_ev;
    assign ev[twi_pkg::EV_WCOL] = wcol_ev;
    assign ev[twi_pkg::EV_TXDONE] = tx_done;
    assign ev[twi_pkg::EV_MATCH] = match_ev;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            irq_q <= 5'h00;
        end else begin
            irq_q <= (irq_q & ~{5{rd_irq}}) | ev;
        end
    end
    assign irq = |(irq_q & imsk_q);
endmodule

// [twi_asserts.sv]
`timescale 1ns/10ps
// Watches the bus handshake and the open-drain pins from outside the block
module twi_asserts (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Register bus
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // Two-wire pins
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_o,
    input wire logic sda_oe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // Transfers taken at this edge
    wire rd_take = hsel && htrans[1] && hready && !hwrite;
    wire wr_take = hsel && htrans[1] && hready && hwrite;

    AST_OKAY: assert property (!hresp)
        else $error("response not okay");
    AST_RD_WAIT: assert property (rd_take |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    AST_WR_NOWAIT: assert property (wr_take |=> hreadyout)
        else $error("write stalled");
    AST_ONE_WAIT: assert property (!hreadyout |=> hreadyout)
        else $error("wait longer than one cycle");
    AST_SCL_OD: assert property (!scl_o)
        else $error("clock pin driven high");
    AST_SDA_OD: assert property (!sda_o)
        else $error("data pin driven high");
    // Data may only move while the clock line is held low
    AST_SDA_CHG: assert property ($changed(sda_oe) |-> scl_oe)
        else $error("data changed with clock high");
    AST_RDATA: assert property ($changed(hrdata) |-> $past(rd_take) ||
        $past(rd_take, 2))
        else $error("read data moved without a read");
endmodule
bind twi_addr_data_regs twi_asserts i_chk (.clk_sys, .nrst, .hsel,
    .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata, .scl_o,
    .scl_oe, .sda_o, .sda_oe);

// [twi_peer.sv]
`timescale 1ns/10ps
// Far-side master; it also records every bit seen on a clock rise
module twi_peer #(
    parameter int HALF = 6
) (
    // Clock
    input wire logic clk_sys,
    // Line levels
    input wire logic scl,
    input wire logic sda,
    // Pull-downs, high pulls the line low
    output logic scl_low,
    output logic sda_low,
    // Last nine bits seen
    output logic [8:0] got
);
    // Lines released outside frames, so the pull-ups hold them high
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
        got = 9'h000;
    end
    // Sample on clock rise, first bit ends up on top
    always @(posedge scl) begin
        got <= {got[7:0], sda};
    end
    task automatic half;
        repeat (HALF) @(posedge clk_sys);
    endtask
    // Data falls while clock is high
    task automatic start;
        sda_low <= 1'b1;
        half();
        scl_low <= 1'b1;
        half();
    endtask
    // Eight bits first-high, ninth slot released
    task automatic put_byte(input logic [7:0] b);
        logic [8:0] s;
        s = {b, 1'b1};
        for (int i = 8; i >= 0; i--) begin
            sda_low <= !s[i];
            half();
            scl_low <= 1'b0;
            half();
            scl_low <= 1'b1;
        end
    endtask
    // Data rises while clock is high
    task automatic stop;
        sda_low <= 1'b1;
        half();
        scl_low <= 1'b0;
        half();
        sda_low <= 1'b0;
        half();
    endtask
endmodule

// [tb_top.sv]
`timescale 1ns/10ps
module tb_top;
    logic clk_sys, nrst, hsel, hwrite, hreadyout, hresp, irq, m;
    logic scl_o, scl_oe, sda_o, sda_oe, scl_low, sda_low;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [8:0] got;
    int mismatches, check_count, n;
    // Open-drain lines with pull-ups
    wire scl = !(scl_oe || scl_low);
    wire sda = !(sda_oe || sda_low);

    twi_addr_data_regs i_dut (.clk_sys, .nrst, .hsel, .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout,
        .hresp, .hrdata, .scl_i(scl), .scl_o, .scl_oe, .sda_i(sda),
        .sda_o, .sda_oe, .irq);
    twi_peer i_peer (.clk_sys, .scl, .sda, .scl_low, .sda_low, .got);

    task automatic chk(input string s, input logic [31:0] v, e);
        check_count++;
        if (v !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", s, e, v);
        end
    endtask
    // One single transfer; waits on ready, never on a fixed count
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk_sys); while (!hreadyout);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (!hreadyout);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] t;
        xfer(1'b1, a, d, t);
    endtask
    task automatic rd(input logic [7:0] a);
        xfer(1'b0, a, 32'h0, r);
    endtask
    // Whole frame from the far side, bytes taken from the top
    task automatic send(input logic [31:0] b, input int k);
        i_peer.start();
        for (int i = 0; i < k; i++) i_peer.put_byte(b[31 - 8 * i -: 8]);
        i_peer.stop();
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic t_reset;
        rd(twi_pkg::OFS_OWN);
        chk("own", r, 32'h0);
        rd(twi_pkg::OFS_MASK);
        chk("mask", r, 32'h0);
        rd(twi_pkg::OFS_DIV);
        chk("div", r, 32'h0);
        rd(twi_pkg::OFS_TX);
        chk("tx", r, 32'h0);
        rd(twi_pkg::OFS_RX);
        chk("rx", r, 32'h0);
    endtask
    task automatic t_regs;
        wr(twi_pkg::OFS_OWN, 32'h0000_03FF);
        wr(twi_pkg::OFS_MASK, 32'h0000_0155);
        wr(twi_pkg::OFS_DIV, 32'h0000_0ABC);
        wr(twi_pkg::OFS_TX, 32'h0000_005A);
        rd(twi_pkg::OFS_OWN);
        chk("own", r, 32'h0000_03FF);
        rd(twi_pkg::OFS_MASK);
        chk("mask", r, 32'h0000_0155);
        rd(twi_pkg::OFS_DIV);
        chk("div", r, 32'h0000_0ABC);
        rd(twi_pkg::OFS_TX);
        chk("tx", r, 32'h0000_005A);
        rd(8'h24);
        chk("unmapped", r, 32'h0);
    endtask
    // Seven-bit matching; own bits 9 and 8 set and must not matter
    task automatic t_match;
        logic [9:0] mk [3] = '{10'h000, 10'h002, 10'h000};
        logic [7:0] ad [3] = '{8'h54, 8'h56, 8'h56};
        logic [7:0] ex [3] = '{8'h11, 8'h22, 8'h22};
        logic [7:0] dt [3] = '{8'h11, 8'h22, 8'h33};
        wr(twi_pkg::OFS_CTRL, 32'h0000_0001);
        wr(twi_pkg::OFS_OWN, 32'h0000_0354);
        wr(twi_pkg::OFS_IMSK, 32'h0000_0001);
        rd(twi_pkg::OFS_IRQ);
        for (int i = 0; i < 3; i++) begin
            m = (i < 2);
            wr(twi_pkg::OFS_MASK, {22'h0, mk[i]});
            send({ad[i], dt[i], 16'h0}, 2);
            chk("irq high", {31'h0, irq}, {31'h0, m});
            rd(twi_pkg::OFS_RX);
            chk("rx", r, {24'h0, ex[i]});
            rd(twi_pkg::OFS_IRQ);
            chk("events", {30'h0, r[4], r[0]}, {30'h0, m, m});
            chk("irq low", {31'h0, irq}, 32'h0);
        end
    endtask
    task automatic t_ovf;
        wr(twi_pkg::OFS_MASK, 32'h0);
        send({8'h54, 8'hA1, 8'hB2, 8'h0}, 3);
        rd(twi_pkg::OFS_STAT);
        chk("full ovf", {30'h0, r[1:0]}, 32'h3);
        rd(twi_pkg::OFS_RX);
        chk("kept", r, 32'h0000_00A1);
        rd(twi_pkg::OFS_STAT);
        chk("ovf sticky", {30'h0, r[1:0]}, 32'h2);
        wr(twi_pkg::OFS_STAT, 32'h0000_0002);
        rd(twi_pkg::OFS_STAT);
        chk("ovf clear", {31'h0, r[1]}, 32'h0);
    endtask
    // Ten-bit header then low byte; mask bit 0 counts only here
    task automatic t_ten;
        wr(twi_pkg::OFS_CTRL, 32'h0000_0003);
        wr(twi_pkg::OFS_OWN, 32'h0000_02B5);
        wr(twi_pkg::OFS_MASK, 32'h0000_0001);
        send({8'hF4, 8'hB4, 8'h5C, 8'h0}, 3);
        rd(twi_pkg::OFS_RX);
        chk("ten mask", r, 32'h0000_005C);
        wr(twi_pkg::OFS_MASK, 32'h0);
        send({8'hF4, 8'hB4, 8'h6D, 8'h0}, 3);
        rd(twi_pkg::OFS_RX);
        chk("ten miss", r, 32'h0000_005C);
        wr(twi_pkg::OFS_CTRL, 32'h0000_0001);
        send({8'hB4, 8'h77, 16'h0}, 2);
        rd(twi_pkg::OFS_RX);
        chk("seven", r, 32'h0000_0077);
    endtask
    task automatic t_tx;
        wr(twi_pkg::OFS_DIV, 32'h0000_0002);
        wr(twi_pkg::OFS_IMSK, 32'h0);
        wr(twi_pkg::OFS_TX, 32'h0000_00C3);
        wr(twi_pkg::OFS_TX, 32'h0000_0099);
        // Low half period must last divisor plus one cycles
        n = 0;
        while (scl_oe) @(posedge clk_sys);
        while (!scl_oe) @(posedge clk_sys);
        while (scl_oe) begin
            n++;
            @(posedge clk_sys);
        end
        chk("low half", n, 32'h3);
        do rd(twi_pkg::OFS_STAT); while (r[3]);
        chk("wcol", {31'h0, r[2]}, 32'h1);
        chk("shifted", {23'h0, got}, 32'h0000_0187);
        chk("masked irq", {31'h0, irq}, 32'h0);
        rd(twi_pkg::OFS_TX);
        chk("tx kept", r, 32'h0000_00C3);
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // Hang guard, well above the expected few thousand cycles
    initial begin
        repeat (40000) @(posedge clk_sys);
        mismatches++;
        close_out();
    end
    initial begin
        nrst = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        t_reset();
        t_regs();
        t_match();
        t_ovf();
        t_ten();
        t_tx();
        close_out();
    end
endmodule
